// ### core/rtc_cell_mem.sv
// Sixteen-byte cell array holding the host-visible clock bytes.
// One write port, one read port; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module rtc_cell_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] cells [16];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      cells[waddr] <= wdata;
    end
    rdata <= cells[raddr];
  end
endmodule
`default_nettype wire

// ### core/rtc_pkg.sv
// Shared constants and carriers for the clock-calendar supervisor.
// Assumes a 40 MHz system clock and a byte-wide asynchronous host bus.
package rtc_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_CENTURY = 4'h1;
  localparam logic [3:0] ADDR_ALM_SEC = 4'h2;
  localparam logic [3:0] ADDR_ALM_MIN = 4'h3;
  localparam logic [3:0] ADDR_ALM_HOUR = 4'h4;
  localparam logic [3:0] ADDR_ALM_DATE = 4'h5;
  localparam logic [3:0] ADDR_ALM_MONTH = 4'h6;
  localparam logic [3:0] ADDR_WATCHDOG = 4'h7;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_SEC = 4'h9;
  localparam logic [3:0] ADDR_MIN = 4'hA;
  localparam logic [3:0] ADDR_HOUR = 4'hB;
  localparam logic [3:0] ADDR_DAY = 4'hC;
  localparam logic [3:0] ADDR_DATE = 4'hD;
  localparam logic [3:0] ADDR_MONTH = 4'hE;
  localparam logic [3:0] ADDR_YEAR = 4'hF;
  // Field positions
  localparam int FLAG_WATCHDOG = 7;
  localparam int FLAG_ALARM = 6;
  localparam int FLAG_BATTERY_LOW = 4;
  localparam int CTL_WRITE = 7;
  localparam int CTL_READ = 6;
  localparam int SEC_STOP = 7;
  localparam int ALM_IRQ_ENABLE = 7;
  localparam int WATCHDOG_ROUTE_SELECT = 7;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] WATCHDOG_RESET = 8'h00;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] CENTURY_RESET = 8'h20;
  localparam logic [7:0] DATE_RESET = 8'h01;
  localparam logic [7:0] MONTH_RESET = 8'h01;
  localparam logic [7:0] DAY_RESET = 8'h01;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SECOND_NS = 1000000000;
  localparam int SIXTEENTHS_PER_SECOND = 16;
  localparam int SIXTEENTH_CYCLES = SECOND_NS / CLK_PERIOD_NS / SIXTEENTHS_PER_SECOND;
  localparam logic [3:0] COPY_LAST = 4'h8;

  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } time_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic ex_n;
    logic bank;
    logic supply_bad;
    logic below_switch;
    logic battery_low;
    logic kick;
  } pins_t;
endpackage

// ### core/rtc_supervisor.sv
// Clock-calendar supervisor behind an SRAM-style byte port.
// Assumes asynchronous bus pins, a power-fail comparator and a battery monitor.
`timescale 1ns/1ps
`default_nettype none
module rtc_supervisor #(
  parameter int SIXTEENTH_CYCLES = rtc_pkg::SIXTEENTH_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] register_select_lines,
  input wire logic [7:0] data_lines_in,
  output logic [7:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic chip_enable_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic external_ram_select_in_n,
  input wire logic bank_select,
  input wire logic supply_fault,
  input wire logic battery_switch_threshold,
  input wire logic battery_low,
  input wire logic watchdog_kick,
  output logic ram_enable_one_n,
  output logic ram_enable_two_n,
  output logic backup_supply_out,
  output logic reset_out,
  output logic reset_out_oe,
  output logic interrupt_freq_test_out,
  output logic interrupt_freq_test_out_oe
);
  localparam int DIV_W = $clog2(SIXTEENTH_CYCLES + 1);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02)
      month_days = leap ? 8'h29 : 8'h28;
    else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
      month_days = 8'h30;
    else
      month_days = 8'h31;
  endfunction

  function automatic rtc_pkg::time_t advance(input rtc_pkg::time_t t);
    rtc_pkg::time_t n;
    n = t;
    n.sec = {t.sec[rtc_pkg::SEC_STOP], 7'(bcd_inc({1'b0, t.sec[6:0]}))};
    if (t.sec[6:0] == 7'h59)
    begin
      n.sec[6:0] = 7'h00;
      n.min = bcd_inc(t.min);
      if (t.min == 8'h59)
      begin
        n.min = 8'h00;
        n.hour = bcd_inc(t.hour);
        if (t.hour == 8'h23)
        begin
          n.hour = 8'h00;
          n.day = (t.day[2:0] == 3'h7) ? 8'h01 : {5'h00, t.day[2:0] + 3'h1};
          n.date = bcd_inc(t.date);
          if (t.date >= month_days(t.month, t.year))
          begin
            n.date = 8'h01;
            n.month = (t.month == 8'h12) ? 8'h01 : bcd_inc(t.month);
            if (t.month == 8'h12)
            begin
              n.year = (t.year == 8'h99) ? 8'h00 : bcd_inc(t.year);
              n.century = (t.year == 8'h99) ? bcd_inc(t.century) : t.century;
            end
          end
        end
      end
    end
    advance = n;
  endfunction

  // Three-stage pin synchroniser; a bit changes once stages two and three agree
  rtc_pkg::pins_t raw, s1, s2, s3, pin;
  assign raw = '{addr: register_select_lines, data: data_lines_in, ce_n: chip_enable_n,
    we_n: write_enable_n, oe_n: output_enable_n, ex_n: external_ram_select_in_n, bank: bank_select,
    supply_bad: supply_fault, below_switch: battery_switch_threshold, battery_low: battery_low,
    kick: watchdog_kick};
  wire [$bits(rtc_pkg::pins_t)-1:0] agree = ~(s2 ^ s3);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1 <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ex_n: 1'b1, default: '0};
      s2 <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ex_n: 1'b1, default: '0};
      s3 <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ex_n: 1'b1, default: '0};
      pin <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, ex_n: 1'b1, default: '0};
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      pin <= (s3 & agree) | (pin & ~agree);
    end
  end

  // Bus decode and external RAM steering
  wire power_bad = pin.supply_bad || pin.below_switch;
  wire sel = !pin.ce_n && !power_bad;
  wire rd_cycle = sel && pin.we_n;
  wire wr_cycle = sel && !pin.we_n;
  assign data_lines_oe = rd_cycle && !pin.oe_n;
  assign ram_enable_one_n = !(!pin.ex_n && !pin.bank && !power_bad);
  assign ram_enable_two_n = !(!pin.ex_n && pin.bank && !power_bad);
  assign backup_supply_out = pin.below_switch;

  // Write capture: data latched while write is low, committed at its end
  logic wr_active;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  wire commit = wr_active && !wr_cycle && !power_bad;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_active <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_active <= wr_cycle;
      if (wr_cycle)
      begin
        wr_addr <= pin.addr;
        wr_data <= pin.data;
      end
    end
  end

  // Timebases: 1/16 second enable and one-second enable
  logic [DIV_W-1:0] div;
  logic [3:0] sixteenth;
  wire tick16 = (div == DIV_W'(SIXTEENTH_CYCLES - 1));
  wire tick1 = tick16 && (sixteenth == 4'(rtc_pkg::SIXTEENTHS_PER_SECOND - 1));

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div <= '0;
      sixteenth <= 4'h0;
    end
    else
    begin
      div <= tick16 ? '0 : div + DIV_W'(1);
      if (tick16)
      begin
        sixteenth <= sixteenth + 4'h1;
      end
    end
  end

  // Control and setting registers
  logic [7:0] clock_control, watchdog_setting, century_value;
  logic [7:0] alarm [5];
  wire set_mode = clock_control[rtc_pkg::CTL_WRITE];
  wire freeze = set_mode || clock_control[rtc_pkg::CTL_READ];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      clock_control <= rtc_pkg::CONTROL_RESET;
      watchdog_setting <= rtc_pkg::WATCHDOG_RESET;
      for (int i = 0; i < 5; i++)
        alarm[i] <= rtc_pkg::ALARM_RESET;
    end
    else if (commit)
    begin
      if (wr_addr == rtc_pkg::ADDR_CONTROL)
        clock_control <= wr_data;
      if (wr_addr == rtc_pkg::ADDR_WATCHDOG)
        watchdog_setting <= wr_data;
      if (wr_addr >= rtc_pkg::ADDR_ALM_SEC && wr_addr <= rtc_pkg::ADDR_ALM_MONTH)
        alarm[3'(wr_addr - rtc_pkg::ADDR_ALM_SEC)] <= wr_data;
    end
  end

  // Running counters; host writes load them only while the write bit is set, except century, which loads on any write
  rtc_pkg::time_t now;
  wire time_wr = commit && set_mode;
  assign century_value = now.century;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      now <= '{century: rtc_pkg::CENTURY_RESET, month: rtc_pkg::MONTH_RESET, date: rtc_pkg::DATE_RESET,
        day: rtc_pkg::DAY_RESET, default: rtc_pkg::ZERO_RESET};
    else if (time_wr || (commit && wr_addr == rtc_pkg::ADDR_CENTURY))
      unique case (wr_addr)
        rtc_pkg::ADDR_SEC: now.sec <= wr_data;
        rtc_pkg::ADDR_MIN: now.min <= wr_data;
        rtc_pkg::ADDR_HOUR: now.hour <= wr_data;
        rtc_pkg::ADDR_DAY: now.day <= wr_data;
        rtc_pkg::ADDR_DATE: now.date <= wr_data;
        rtc_pkg::ADDR_MONTH: now.month <= wr_data;
        rtc_pkg::ADDR_YEAR: now.year <= wr_data;
        rtc_pkg::ADDR_CENTURY: now.century <= wr_data;
        default: now <= now;
      endcase
    else if (tick1 && !set_mode && !now.sec[rtc_pkg::SEC_STOP])
      now <= advance(now);
  end

  // Copy walker refreshes the eight clock cells and writes the century into the flags cell after each second while neither the read nor the write bit is set
  logic copying;
  logic [3:0] copy_idx;
  wire copy_go = copying && !commit;
  wire [3:0] copy_addr = (copy_idx == rtc_pkg::COPY_LAST) ? rtc_pkg::ADDR_CENTURY : rtc_pkg::ADDR_SEC + copy_idx;
  wire [7:0] copy_data = now[{copy_idx[2:0], 3'h0} +: 8] & {8{copy_idx != rtc_pkg::COPY_LAST}}
    | now.century & {8{copy_idx == rtc_pkg::COPY_LAST}};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      copying <= 1'b0;
      copy_idx <= 4'h0;
    end
    else if (tick1 && !freeze)
    begin
      copying <= 1'b1;
      copy_idx <= 4'h0;
    end
    else if (copy_go)
    begin
      copying <= (copy_idx != rtc_pkg::COPY_LAST);
      copy_idx <= copy_idx + 4'h1;
    end
  end

  logic [7:0] cell_rdata;
  rtc_cell_mem cells (
    .clk(clk),
    .we(commit || copy_go),
    .waddr(commit ? wr_addr : copy_addr),
    .wdata(commit ? wr_data : copy_data),
    .raddr(pin.addr),
    .rdata(cell_rdata)
  );

  // Alarm compare one cycle after the counters move
  logic check;
  wire alarm_hit = (alarm[4][4:0] == now.month[4:0]) && (alarm[3][5:0] == now.date[5:0])
    && (alarm[2][5:0] == now.hour[5:0]) && (alarm[1][6:0] == now.min[6:0])
    && (alarm[0][6:0] == now.sec[6:0]);

  // Watchdog in 1/16 second units: resolution 1, 4, 16 or 64 units times multiplier
  logic [10:0] wd_count;
  logic kick_d;
  wire [10:0] wd_limit = {6'h00, watchdog_setting[6:2]} << {watchdog_setting[1:0], 1'b0};
  wire wd_restart = (pin.kick && !kick_d) || (commit && wr_addr == rtc_pkg::ADDR_WATCHDOG);
  wire wd_expire = tick16 && (wd_limit != 11'h000) && (wd_count + 11'h001 >= wd_limit);

  // Watchdog and alarm flags: sticky, cleared when a flags read ends; a new event wins; battery low is live
  logic flag_wd, flag_alarm, flag_rd_d;
  wire flag_rd = rd_cycle && pin.addr == rtc_pkg::ADDR_FLAGS;
  wire flag_clear = flag_rd_d && !flag_rd;
  wire route_irq = watchdog_setting[rtc_pkg::WATCHDOG_ROUTE_SELECT];
  logic reset_pulse;
  wire [7:0] status_flags = {flag_wd, flag_alarm, 1'b0, pin.battery_low, 4'h0};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      check <= 1'b0;
      wd_count <= 11'h000;
      kick_d <= 1'b0;
      flag_wd <= 1'b0;
      flag_alarm <= 1'b0;
      flag_rd_d <= 1'b0;
      reset_pulse <= 1'b0;
    end
    else
    begin
      check <= tick1;
      kick_d <= pin.kick;
      flag_rd_d <= flag_rd;
      if (wd_restart || wd_expire)
        wd_count <= 11'h000;
      else if (tick16)
        wd_count <= wd_count + 11'h001;
      if (check && alarm_hit)
        flag_alarm <= 1'b1;
      else if (flag_clear)
        flag_alarm <= 1'b0;
      if (wd_expire)
        flag_wd <= 1'b1;
      else if (flag_clear)
        flag_wd <= 1'b0;
      if (wd_expire && !route_irq)
        reset_pulse <= 1'b1;
      else if (tick16)
        reset_pulse <= 1'b0;
    end
  end

  assign reset_out = 1'b0;
  assign reset_out_oe = reset_pulse;
  assign interrupt_freq_test_out = 1'b0;
  assign interrupt_freq_test_out_oe = (flag_alarm && alarm[4][rtc_pkg::ALM_IRQ_ENABLE])
    || (flag_wd && route_irq);

  // Read data register; flags come live, other bytes from their holders
  logic [3:0] rd_addr_d;
  logic [7:0] reg_value;
  always_comb
  begin
    unique case (rd_addr_d)
      rtc_pkg::ADDR_FLAGS: reg_value = status_flags;
      rtc_pkg::ADDR_CENTURY: reg_value = century_value;
      rtc_pkg::ADDR_WATCHDOG: reg_value = watchdog_setting;
      rtc_pkg::ADDR_CONTROL: reg_value = clock_control;
      default: reg_value = cell_rdata;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_addr_d <= 4'h0;
      data_lines_out <= 8'h00;
    end
    else
    begin
      rd_addr_d <= pin.addr;
      data_lines_out <= (rd_addr_d >= rtc_pkg::ADDR_ALM_SEC && rd_addr_d <= rtc_pkg::ADDR_ALM_MONTH)
        ? alarm[3'(rd_addr_d - rtc_pkg::ADDR_ALM_SEC)] : reg_value;
    end
  end
endmodule
`default_nettype wire

// ### tb/rtc_host_model.sv
// Host processor model issuing byte-wide SRAM-style register cycles.
// Drives after falling clock edges; resolves the shared data bus.
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  input wire logic clk,
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  output logic [3:0] addr,
  output logic [7:0] bus,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  logic [7:0] wd = 8'h00;
  logic drv = 1'b0;
  // Released bus shows the inverse of the last driven byte
  assign bus = dev_oe ? dev_data : drv ? wd : ~wd;
  initial
  begin
    addr = 4'h0;
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
  end
  task automatic write_byte(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    drv = 1'b1;
    ce_n = 1'b0; // Only while the RAM select is idle
    we_n = 1'b0;
    repeat (6) @(negedge clk);
    we_n = 1'b1;
    repeat (6) @(negedge clk);
    ce_n = 1'b1;
    drv = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic read_byte(input logic [3:0] a, input logic g, output logic [7:0] d, output logic v);
    @(negedge clk);
    addr = a;
    ce_n = 1'b0;
    oe_n = g;
    repeat (8) @(negedge clk);
    d = dev_data;
    v = dev_oe;
    ce_n = 1'b1;
    oe_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### tb/rtc_supervisor_assertions.sv
// Checker for the supervisor pins: RAM enables, data drive, backup, open drain.
// Bound to rtc_supervisor; pin changes settle within six clocks.
`timescale 1ns/1ps
`default_nettype none
module rtc_supervisor_assertions #(
  parameter int SIXTEENTH_CYCLES = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic chip_enable_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic external_ram_select_in_n,
  input wire logic bank_select,
  input wire logic supply_fault,
  input wire logic battery_switch_threshold,
  input wire logic data_lines_oe,
  input wire logic ram_enable_one_n,
  input wire logic ram_enable_two_n,
  input wire logic backup_supply_out,
  input wire logic reset_out,
  input wire logic reset_out_oe,
  input wire logic interrupt_freq_test_out,
  input wire logic interrupt_freq_test_out_oe
);
  localparam int PULSE_MAX = 2 * SIXTEENTH_CYCLES;
  wire pf = supply_fault | battery_switch_threshold;
  wire ex = external_ram_select_in_n;
  wire one = ram_enable_one_n;
  wire two = ram_enable_two_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_read_held;
    (!chip_enable_n && !output_enable_n && write_enable_n && !pf && ex) [*6];
  endsequence
  sequence s_fault_held;
    pf [*6];
  endsequence
  ram_one_sel_a: assert property ((!ex && !bank_select && !pf) [*6] |-> !one && two)
    else $error("ram enable one not alone");
  ram_two_sel_a: assert property ((!ex && bank_select && !pf) [*6] |-> one && !two)
    else $error("ram enable two not alone");
  ram_deselect_a: assert property ((ex && !pf) [*6] |-> one && two)
    else $error("ram enable active while deselected");
  ram_fault_safe_a: assert property (s_fault_held |-> one && two)
    else $error("ram enable active under power fault");
  fault_no_drive_a: assert property (s_fault_held |-> !data_lines_oe)
    else $error("data driven under power fault");
  read_drive_a: assert property (s_read_held |-> data_lines_oe)
    else $error("read cycle not driven");
  idle_no_drive_a: assert property ((chip_enable_n || output_enable_n || !write_enable_n) [*6]
    |-> !data_lines_oe)
    else $error("data driven outside read");
  backup_on_a: assert property (battery_switch_threshold [*6] |-> backup_supply_out)
    else $error("battery switch missing");
  backup_off_a: assert property (!battery_switch_threshold [*6] |-> !backup_supply_out)
    else $error("battery switch stuck");
  reset_pulse_a: assert property ($rose(reset_out_oe) |-> ##[1:PULSE_MAX] !reset_out_oe)
    else $error("reset pulse too long");
  open_drain_a: assert property (reset_out_oe || interrupt_freq_test_out_oe
    |-> !reset_out && !interrupt_freq_test_out)
    else $error("open drain pin driven high");
endmodule
`default_nettype wire

// ### tb/rtc_supervisor_tb.sv
// Self-checking bench for the clock-calendar supervisor.
// Host model runs register cycles; power and RAM select pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module rtc_supervisor_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic external_ram_select_in_n = 1'b1;
  logic bank_select = 1'b0;
  logic supply_fault = 1'b0;
  logic battery_switch_threshold = 1'b0;
  logic battery_low = 1'b0;
  logic watchdog_kick = 1'b0;
  logic [3:0] register_select_lines;
  logic [7:0] data_lines_in, data_lines_out, rd;
  logic data_lines_oe, chip_enable_n, write_enable_n, output_enable_n, v;
  logic ram_enable_one_n, ram_enable_two_n, backup_supply_out;
  logic reset_out, reset_out_oe, interrupt_freq_test_out, interrupt_freq_test_out_oe;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  rtc_host_model u_host (.clk, .dev_data(data_lines_out), .dev_oe(data_lines_oe),
    .addr(register_select_lines), .bus(data_lines_in), .ce_n(chip_enable_n),
    .we_n(write_enable_n), .oe_n(output_enable_n));
  rtc_supervisor #(.SIXTEENTH_CYCLES(4)) u_dut (.clk, .resetn, .register_select_lines,
    .data_lines_in, .data_lines_out, .data_lines_oe, .chip_enable_n, .write_enable_n,
    .output_enable_n, .external_ram_select_in_n, .bank_select, .supply_fault,
    .battery_switch_threshold, .battery_low, .watchdog_kick, .ram_enable_one_n,
    .ram_enable_two_n, .backup_supply_out, .reset_out, .reset_out_oe,
    .interrupt_freq_test_out, .interrupt_freq_test_out_oe);
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.write_byte(a, d);
  endtask
  task automatic rdb(input logic [3:0] a);
    u_host.read_byte(a, 1'b0, rd, v);
  endtask
  task automatic wait_pin(input bit irq);
    for (int i = 0; i < 200; i++)
    begin
      if ((irq ? interrupt_freq_test_out_oe : reset_out_oe) === 1'b1)
        break;
      @(negedge clk);
    end
  endtask
  task automatic set_time(input logic [7:0] d, input logic [7:0] m, input logic [7:0] y);
    wr(4'h8, 8'h80);
    wr(4'h9, 8'h59);
    wr(4'hA, 8'h59);
    wr(4'hB, 8'h23);
    wr(4'hD, d);
    wr(4'hE, m);
    wr(4'hF, y);
    wr(4'h8, 8'h00);
  endtask
  task automatic t_regs;
    rdb(4'h7);
    check8(rd, rtc_pkg::WATCHDOG_RESET);
    wr(4'h1, 8'h19);
    rdb(4'h1);
    check8(rd, 8'h19);
    u_host.read_byte(4'h1, 1'b1, rd, v);
    check8({7'h00, v}, 8'h00);
    wr(4'h8, 8'h25);
    rdb(4'h8);
    check8(rd, 8'h25);
    wr(4'h8, 8'h00);
    supply_fault = 1'b1;
    wr(4'h1, 8'h55);
    supply_fault = 1'b0;
    rdb(4'h1);
    check8(rd, 8'h19);
    battery_low = 1'b1;
    wr(4'h0, 8'hFF);
    rdb(4'h0);
    check8(rd & 8'hD0, 8'h10);
    battery_low = 1'b0;
  endtask
  task automatic t_ram;
    logic f;
    for (int i = 0; i < 16; i++)
    begin
      {battery_switch_threshold, supply_fault, bank_select, external_ram_select_in_n} = 4'(i);
      f = supply_fault | battery_switch_threshold | external_ram_select_in_n;
      repeat (6) @(negedge clk);
      check8({ram_enable_one_n, ram_enable_two_n}, {f | bank_select, f | ~bank_select});
      check8(backup_supply_out, battery_switch_threshold);
    end
    {battery_switch_threshold, supply_fault, bank_select, external_ram_select_in_n} = 4'h1;
    repeat (6) @(negedge clk);
  endtask
  task automatic t_cal;
    logic [7:0] dd[3] = '{8'h28, 8'h28, 8'h30};
    logic [7:0] mm[3] = '{8'h02, 8'h02, 8'h04};
    logic [7:0] yy[3] = '{8'h23, 8'h24, 8'h23};
    logic [15:0] ex[3] = '{16'h0103, 16'h2902, 16'h0105};
    for (int i = 0; i < 3; i++)
    begin
      set_time(dd[i], mm[i], yy[i]);
      repeat (80) @(negedge clk);
      rdb(4'hD);
      check8(rd, ex[i][15:8]);
      rdb(4'hE);
      check8(rd, ex[i][7:0]);
    end
  endtask
  task automatic t_alarm;
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h81);
    set_time(8'h01, 8'h01, 8'h23);
    wait_pin(1'b1);
    check8(interrupt_freq_test_out_oe, 8'h01);
    rdb(4'h0);
    check8(rd & 8'h40, 8'h40);
    rdb(4'h0);
    check8(rd & 8'h40, 8'h00);
    check8(interrupt_freq_test_out_oe, 8'h00);
  endtask
  task automatic t_wdog;
    wr(4'h7, 8'h06);
    wait_pin(1'b0);
    check8(reset_out_oe, 8'h01);
    rdb(4'h0);
    check8(rd & 8'h80, 8'h80);
    wr(4'h7, 8'h86);
    wait_pin(1'b1);
    check8({interrupt_freq_test_out_oe, reset_out_oe}, 8'h02);
    wr(4'h7, 8'h00);
    rdb(4'h0);
    rdb(4'h0);
    check8(rd & 8'h80, 8'h00);
    check8(interrupt_freq_test_out_oe, 8'h00);
  endtask
  task automatic t_kick;
    logic seen;
    seen = 1'b0;
    wr(4'h7, 8'h06);
    for (int k = 0; k < 240; k++)
    begin
      watchdog_kick = (k % 40) < 4;
      seen = seen | reset_out_oe;
      @(negedge clk);
    end
    check8({7'h00, seen}, 8'h00);
    wr(4'h7, 8'h00);
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (6) @(negedge clk);
    t_regs();
    t_ram();
    t_cal();
    t_alarm();
    t_wdog();
    t_kick();
    final_report();
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      num_errors++;
      final_report();
    end
  end
endmodule
bind rtc_supervisor rtc_supervisor_assertions #(.SIXTEENTH_CYCLES(SIXTEENTH_CYCLES)) u_chk (.clk, .resetn,
  .chip_enable_n, .write_enable_n, .output_enable_n, .external_ram_select_in_n, .bank_select,
  .supply_fault, .battery_switch_threshold, .data_lines_oe, .ram_enable_one_n, .ram_enable_two_n,
  .backup_supply_out, .reset_out, .reset_out_oe, .interrupt_freq_test_out, .interrupt_freq_test_out_oe);
`default_nettype wire
